/* verification/reference_ladder_control_test.sv */
`timescale 1ns/1ns
`default_nettype none

module reference_ladder_control_test;
  import rlc_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd, port_a_direction, port_a_latch;
  logic sleep_active, pad, ext_drive, ext_level, shared_analog_pin_out;
  logic shared_analog_pin_oe_b, shared_pin_digital_in, ladder_power_enable;
  logic ladder_pin_output_enable, ladder_range_select, ladder_source_select;
  logic [3:0]  reg_addr, ladder_tap_value;
  logic [7:0]  reg_wdata, reg_rdata, level_x96, v, r;
  logic [15:0] ladder_switch_sel;
  logic [4:0]  level_numerator;
  logic [5:0]  level_denominator;
  logic [31:0] seed = 32'h0000_b68c;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;

  rlc_ladder_ctrl u_dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_a_direction, .port_a_latch, .sleep_active,
    .shared_analog_pin_in(pad), .shared_analog_pin_out,
    .shared_analog_pin_oe_b, .shared_pin_digital_in, .ladder_power_enable,
    .ladder_pin_output_enable, .ladder_range_select, .ladder_source_select,
    .ladder_tap_value, .ladder_switch_sel, .level_numerator,
    .level_denominator);

  rlc_ladder_model u_far (.sys_clk, .power_en(ladder_power_enable),
    .route_en(ladder_pin_output_enable), .numerator(level_numerator),
    .denominator(level_denominator), .pin_out(shared_analog_pin_out),
    .pin_oe_b(shared_analog_pin_oe_b), .ext_drive, .ext_level, .pad,
    .level_x96);

  // ---------------------------------------------------------------
  // clock, hang guard, helpers
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      $display("Error at %0t: run hung", $time);
      close_out();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [7:0] exp_lvl(input logic [7:0] c);
    if (!c[7]) return 8'h00;
    if (c[5]) return {4'h0, c[3:0]} * 8'h04;
    return ({4'h0, c[3:0]} + 8'h08) * 8'h03;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // every ladder output follows the stored byte
  task automatic check_all(input logic [7:0] c);
    logic [7:0] got;
    chk(ladder_power_enable, c[7], "power");
    chk(ladder_pin_output_enable, c[6], "route");
    chk(ladder_range_select, c[5], "range");
    chk(ladder_source_select, c[4], "source");
    chk(ladder_tap_value, c[3:0], "tap");
    chk(ladder_switch_sel, c[7] ? 16'h0001 << c[3:0] : 16'h0000, "sel");
    chk(level_denominator, c[5] ? 6'h18 : 6'h20, "den");
    chk(level_x96, exp_lvl(c), "level");
    rd(RLC_OFS_CTRL, got);
    chk(got, c, "readback");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; port_a_direction = 1'b1; port_a_latch = 1'b0;
    sleep_active = 1'b0; ext_drive = 1'b1; ext_level = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    check_all(RLC_CTRL_RST);
    $display("test reset done");
    // every tap in both ranges, then random bytes
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      v = (i < 32) ? {1'b1, seed[6], i[4], seed[4], i[3:0]} : seed[7:0];
      wr(RLC_OFS_CTRL, v);
      check_all(v);
    end
    $display("test fields done");
    // routing against every direction, pad levels random, pad never left floating
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge sys_clk);
      port_a_direction <= i[0];
      port_a_latch     <= seed[0];
      ext_level        <= seed[1];
      wr(RLC_OFS_CTRL, {1'b1, i[1], 6'h20});
      chk(shared_analog_pin_oe_b, i[1] | i[0], "oe");
      chk(shared_analog_pin_out, seed[0], "out");
      repeat (4) @(posedge sys_clk);
      #1;
      chk(shared_pin_digital_in, i[1] ? 1'b0 : (i[0] ? seed[1] : seed[0]),
          "din");
    end
    $display("test pin done");
    wr(RLC_OFS_CTRL, 8'h5a);
    wr(4'h7, 8'hff);
    wr(RLC_OFS_STAT, 8'hff);
    check_all(8'h5a);
    // routed, direction input, driver off: only routed and oe_input set
    rd(RLC_OFS_STAT, r);
    chk(r, 8'h0a, "status");
    rd(4'h9, r);
    chk(r, RLC_RD_ZERO, "unmapped");
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 8'h00, "rdata idle");
    // write straight into a read, no idle cycle between the strobes
    seed = xs(seed);
    @(posedge sys_clk);
    reg_addr  <= RLC_OFS_CTRL;
    reg_wdata <= seed[15:8];
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1;
    chk(reg_rdata, seed[15:8], "back to back");
    $display("test decode done");
    wr(RLC_OFS_CTRL, 8'hd3);
    wr(RLC_OFS_CTRL, 8'h53);
    sleep_active <= 1'b1;
    repeat (20) @(posedge sys_clk);
    sleep_active <= 1'b0;
    #1;
    check_all(8'h53);
    $display("test sleep done");
    wr(RLC_OFS_CTRL, 8'hff);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    check_all(RLC_CTRL_RST);
    $display("test rereset done");
    close_out();
  end
endmodule

`default_nettype wire

/* verification/rlc_ladder_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// analog ladder and shared pin stand-in
// ---------------------------------------------------------------
module rlc_ladder_model (
  input  wire logic       sys_clk,
  input  wire logic       power_en,
  input  wire logic       route_en,
  input  wire logic [4:0] numerator,
  input  wire logic [5:0] denominator,
  input  wire logic       pin_out,
  input  wire logic       pin_oe_b,
  input  wire logic       ext_drive,
  input  wire logic       ext_level,
  output logic            pad,
  output logic [7:0]      level_x96
);
  logic float_q = 1'b0;

  // an undriven pad wanders, so a stale value never passes for a real one
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // level in 96ths of the source; nothing while the ladder is off
  always_comb begin
    level_x96 = 8'h00;
    if (power_en && denominator == 6'h18) begin
      level_x96 = 8'(numerator) * 8'h04;
    end else if (power_en && denominator == 6'h20) begin
      level_x96 = 8'(numerator) * 8'h03;
    end
  end

  // digital driver wins, then the routed reference, then the outside
  always_comb begin
    if (!pin_oe_b) begin
      pad = pin_out;
    end else if (route_en && power_en) begin
      pad = level_x96 >= 8'h30;
    end else if (ext_drive) begin
      pad = ext_level;
    end else begin
      pad = float_q;
    end
  end
endmodule

`default_nettype wire

/* verilog/rlc_ladder_ctrl.sv */
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - bit 7 powers ladder on or off
// - bit 6 routes reference onto pin
// - routing overrides the pin direction bit
// - bit 5 picks low or high range
// - bit 4 picks reference pins or rails
// - bits 3..0 pick one of sixteen taps
// - low range: tap over 24 times source
// - high range: quarter plus tap over 32
// - reset clears all control fields
// - wake from sleep keeps register contents
module rlc_ladder_ctrl
  import rlc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [RLC_ADDR_W-1:0] reg_addr,
  input  wire logic [RLC_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [RLC_DATA_W-1:0] reg_rdata,
  input  wire logic                  port_a_direction,
  input  wire logic                  port_a_latch,
  input  wire logic                  sleep_active,
  input  wire logic                  shared_analog_pin_in,
  output logic                       shared_analog_pin_out,
  output logic                       shared_analog_pin_oe_b,
  output logic                       shared_pin_digital_in,
  output logic                       ladder_power_enable,
  output logic                       ladder_pin_output_enable,
  output logic                       ladder_range_select,
  output logic                       ladder_source_select,
  output logic      [RLC_TAP_W-1:0]  ladder_tap_value,
  output logic      [RLC_TAPS-1:0]   ladder_switch_sel,
  output logic      [4:0]            level_numerator,
  output logic      [5:0]            level_denominator
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [RLC_DATA_W-1:0] ctrl_q;
  logic [RLC_DATA_W-1:0] ctrl_d;
  logic [RLC_DATA_W-1:0] stat_d;
  logic [RLC_DATA_W-1:0] rdata_q;
  logic                  ctrl_wr;
  logic                  pin_meta_q;
  logic                  pin_sync_q;
  logic                  pin_in_q;
  logic                  pin_oe_b_q;
  logic                  pin_out_q;
  logic [RLC_TAPS-1:0]   switch_d;
  logic [RLC_TAPS-1:0]   switch_q;
  logic [4:0]            numer_d;
  logic [4:0]            numer_q;
  logic [5:0]            denom_d;
  logic [5:0]            denom_q;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  assign ctrl_wr = reg_wr && (reg_addr == RLC_OFS_CTRL);

  // next value: a write replaces the whole byte, nothing else moves it
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = reg_wdata;
    end
  end

  // sleep has no path here, so contents survive any wake
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q <= RLC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // static ladder controls
  // ---------------------------------------------------------------
  // fields leave straight from the flops, no extra pipeline stage
  assign ladder_power_enable      = ctrl_q[RLC_BIT_POWER];
  assign ladder_pin_output_enable = ctrl_q[RLC_BIT_PIN_OE];
  assign ladder_range_select      = ctrl_q[RLC_BIT_RANGE];
  assign ladder_source_select     = ctrl_q[RLC_BIT_SOURCE];
  assign ladder_tap_value = ctrl_q[RLC_TAP_MSB:RLC_TAP_LSB];

  // ---------------------------------------------------------------
  // tap decode
  // ---------------------------------------------------------------
  // decoded from the next value so switches move with the fields
  rlc_tap_decode #(
    .TAP_W       (RLC_TAP_W)
  ) u_decode (
    .tap         (ctrl_d[RLC_TAP_MSB:RLC_TAP_LSB]),
    .range_low   (ctrl_d[RLC_BIT_RANGE]),
    .powered     (ctrl_d[RLC_BIT_POWER]),
    .switch_sel  (switch_d),
    .numerator   (numer_d),
    .denominator (denom_d)
  );

  // decoded ladder selection held in flops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      switch_q <= '0;
      numer_q  <= RLC_HIGH_BASE;
      denom_q  <= RLC_DEN_HIGH;
    end else begin
      switch_q <= switch_d;
      numer_q  <= numer_d;
      denom_q  <= denom_d;
    end
  end

  assign ladder_switch_sel = switch_q;
  assign level_numerator   = numer_q;
  assign level_denominator = denom_q;

  // ---------------------------------------------------------------
  // shared pin
  // ---------------------------------------------------------------
  // pad level is asynchronous, two flops before anything reads it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= shared_analog_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // routing the reference forces the digital driver off, else the
  // driver would fight the ladder whatever the direction bit says
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_oe_b_q <= 1'b1;
      pin_out_q  <= 1'b0;
    end else begin
      pin_oe_b_q <= ctrl_d[RLC_BIT_PIN_OE] | port_a_direction;
      pin_out_q  <= port_a_latch;
    end
  end

  // digital view of the pin reads low while the reference is on it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_in_q <= 1'b0;
    end else begin
      pin_in_q <= pin_sync_q & ~ctrl_d[RLC_BIT_PIN_OE];
    end
  end

  assign shared_analog_pin_oe_b = pin_oe_b_q;
  assign shared_analog_pin_out  = pin_out_q;
  assign shared_pin_digital_in  = pin_in_q;

  // ---------------------------------------------------------------
  // status and read path
  // ---------------------------------------------------------------
  // flags warn of wasted current; they never change behaviour
  always_comb begin
    stat_d = RLC_RD_ZERO;
    stat_d[RLC_ST_ACTIVE]    = ctrl_q[RLC_BIT_POWER];
    stat_d[RLC_ST_ROUTED]    = ctrl_q[RLC_BIT_PIN_OE];
    stat_d[RLC_ST_DRIVEN]    = ~pin_oe_b_q;
    stat_d[RLC_ST_OE_INPUT]  = ctrl_q[RLC_BIT_PIN_OE] & port_a_direction;
    stat_d[RLC_ST_EXT_DRIVE] = ctrl_q[RLC_BIT_SOURCE] & ~pin_oe_b_q;
    // power left on across sleep keeps the ladder drawing current
    stat_d[RLC_ST_SLEEP_ON]  = sleep_active & ctrl_q[RLC_BIT_POWER];
    stat_d[RLC_ST_PIN_LEVEL] = pin_in_q;
  end

  // data stands one cycle after the read strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= RLC_RD_ZERO;
    end else if (reg_rd && reg_addr == RLC_OFS_CTRL) begin
      rdata_q <= ctrl_q;
    end else if (reg_rd && reg_addr == RLC_OFS_STAT) begin
      rdata_q <= stat_d;
    end else begin
      rdata_q <= RLC_RD_ZERO;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_ctrl_write;
    reg_wr && (reg_addr == RLC_OFS_CTRL);
  endsequence

  sequence s_ctrl_read;
    reg_rd && (reg_addr == RLC_OFS_CTRL);
  endsequence

  sequence s_quiet_sleep;
    sleep_active && !reg_wr;
  endsequence

  AST_POWER_FOLLOWS_WRITE: assert property (
    s_ctrl_write |=> ladder_power_enable == $past(reg_wdata[7])
  ) else $error("power enable did not follow write");

  AST_PIN_ROUTE_WRITE: assert property (
    s_ctrl_write |=>
      (ladder_pin_output_enable == $past(reg_wdata[6])) &&
      (!ladder_pin_output_enable || shared_analog_pin_oe_b)
  ) else $error("pin routing did not follow write");

  AST_ROUTE_OVERRIDES_DIR: assert property (
    ladder_pin_output_enable |-> shared_analog_pin_oe_b &&
      !shared_pin_digital_in
  ) else $error("digital driver active while reference routed");

  AST_DIR_WHEN_FREE: assert property (
    !ladder_pin_output_enable |->
      shared_analog_pin_oe_b == $past(port_a_direction)
  ) else $error("direction bit ignored while pin free");

  AST_RANGE_WRITE: assert property (
    s_ctrl_write |=> ladder_range_select == $past(reg_wdata[5])
  ) else $error("range select did not follow write");

  AST_SOURCE_WRITE: assert property (
    s_ctrl_write |=> ladder_source_select == $past(reg_wdata[4])
  ) else $error("source select did not follow write");

  AST_TAP_ONEHOT: assert property (
    ladder_power_enable |->
      $onehot(ladder_switch_sel) && ladder_switch_sel[ladder_tap_value]
  ) else $error("tap switch does not match tap value");

  AST_TAPS_OPEN_OFF: assert property (
    !ladder_power_enable |-> ladder_switch_sel == '0
  ) else $error("tap switch closed while powered down");

  AST_LOW_RANGE_LEVEL: assert property (
    ladder_range_select |->
      (level_denominator == 6'h18) &&
      (level_numerator == {1'b0, ladder_tap_value})
  ) else $error("low range level wrong");

  AST_HIGH_RANGE_LEVEL: assert property (
    !ladder_range_select |->
      (level_denominator == 6'h20) &&
      (level_numerator == {1'b0, ladder_tap_value} + 5'h08)
  ) else $error("high range level wrong");

  AST_RESET_CLEARS: assert property (
    $rose(rst_b) |-> (ctrl_q == 8'h00) && shared_analog_pin_oe_b &&
      (ladder_switch_sel == '0)
  ) else $error("control fields not clear after reset");

  AST_SLEEP_HOLDS: assert property (
    s_quiet_sleep ##1 s_quiet_sleep |=> $stable(ctrl_q)
  ) else $error("control register moved during sleep");

  AST_READ_BACK: assert property (
    s_ctrl_write ##1 s_ctrl_read |=> reg_rdata == $past(reg_wdata, 2)
  ) else $error("read did not return last written value");

  AST_READ_ONE_CYCLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00
  ) else $error("read data stood without a read");

  AST_WRITE_NEXT_EDGE: assert property (
    s_ctrl_write |=> (ladder_tap_value == $past(reg_wdata[3:0])) &&
      (level_numerator == ($past(reg_wdata[5]) ?
        {1'b0, $past(reg_wdata[3:0])} :
        {1'b0, $past(reg_wdata[3:0])} + 5'h08))
  ) else $error("write did not take effect on next edge");

endmodule

`default_nettype wire

/* verilog/rlc_pkg.sv */
`default_nettype none

package rlc_pkg;

  // ---------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------
  localparam int          RLC_ADDR_W    = 4;
  localparam int          RLC_DATA_W    = 8;
  localparam logic [3:0]  RLC_OFS_CTRL  = 4'h0;   // control register
  localparam logic [3:0]  RLC_OFS_STAT  = 4'h1;   // read-only state
  localparam logic [7:0]  RLC_CTRL_RST  = 8'h00;  // all fields clear
  localparam logic [7:0]  RLC_RD_ZERO   = 8'h00;  // unmapped answer

  // ---------------------------------------------------------------
  // control register field positions
  // ---------------------------------------------------------------
  localparam int RLC_BIT_POWER  = 7;
  localparam int RLC_BIT_PIN_OE = 6;
  localparam int RLC_BIT_RANGE  = 5;
  localparam int RLC_BIT_SOURCE = 4;
  localparam int RLC_TAP_MSB    = 3;
  localparam int RLC_TAP_LSB    = 0;
  localparam int RLC_TAP_W      = 4;
  localparam int RLC_TAPS       = 16;

  // ---------------------------------------------------------------
  // status register field positions
  // ---------------------------------------------------------------
  localparam int RLC_ST_ACTIVE    = 0;
  localparam int RLC_ST_ROUTED    = 1;
  localparam int RLC_ST_DRIVEN    = 2;
  localparam int RLC_ST_OE_INPUT  = 3;
  localparam int RLC_ST_EXT_DRIVE = 4;
  localparam int RLC_ST_SLEEP_ON  = 5;
  localparam int RLC_ST_PIN_LEVEL = 6;

  // ---------------------------------------------------------------
  // ladder transfer constants
  // ---------------------------------------------------------------
  localparam logic [5:0] RLC_DEN_LOW   = 6'h18;  // 24ths of source
  localparam logic [5:0] RLC_DEN_HIGH  = 6'h20;  // 32nds of source
  localparam logic [4:0] RLC_HIGH_BASE = 5'h08;  // quarter of 32

endpackage

`default_nettype wire

/* verilog/rlc_tap_decode.sv */
`timescale 1ns/1ns
`default_nettype none

module rlc_tap_decode
  import rlc_pkg::*;
#(
  parameter int TAP_W = RLC_TAP_W
) (
  input  wire logic [TAP_W-1:0]      tap,
  input  wire logic                  range_low,
  input  wire logic                  powered,
  output logic      [(1<<TAP_W)-1:0] switch_sel,
  output logic      [4:0]            numerator,
  output logic      [5:0]            denominator
);

  // ---------------------------------------------------------------
  // one switch per ladder tap
  // ---------------------------------------------------------------
  // all switches open while powered down, so no path through ladder
  genvar gi;
  generate
    for (gi = 0; gi < (1 << TAP_W); gi++) begin : g_tap
      assign switch_sel[gi] = powered && (tap == TAP_W'(gi));
    end
  endgenerate

  // level = numerator / denominator of the ladder source
  always_comb begin
    if (range_low) begin
      numerator   = 5'(tap);
      denominator = RLC_DEN_LOW;
    end else begin
      numerator   = 5'(tap) + RLC_HIGH_BASE;
      denominator = RLC_DEN_HIGH;
    end
  end

endmodule

`default_nettype wire
